// [verilog/omx_cfg.svh]
`ifndef OMX_CFG_SVH
`define OMX_CFG_SVH

// register offsets on the control port
`define OMX_ADDR_ENABLES     8'h63
`define OMX_ADDR_LHP_ROUTE   8'h64
`define OMX_ADDR_RHP_ROUTE   8'h65
`define OMX_ADDR_LHP_GAIN    8'h66
`define OMX_ADDR_RHP_GAIN    8'h67
`define OMX_ADDR_LSPK_ROUTE  8'h69

// mixer enable bits
`define OMX_BIT_LHP_ON       3
`define OMX_BIT_RHP_ON       2
`define OMX_BIT_LSPK_ON      1
`define OMX_BIT_RSPK_ON      0

// route register fields
`define OMX_BIT_PATH_SEL     7
`define OMX_ROUTE_MSB        5
`define OMX_ROUTE_LSB        0

// gain register fields
`define OMX_BIT_SILENCE      8
`define OMX_BIT_INMIX_L_GAIN 7
`define OMX_BIT_INMIX_R_GAIN 6
`define OMX_AUXL_MSB         5
`define OMX_AUXL_LSB         3
`define OMX_AUXR_MSB         2
`define OMX_AUXR_LSB         0

// writable masks and reset values
`define OMX_MASK_ENABLES     16'h000f
`define OMX_MASK_ROUTE       16'h00bf
`define OMX_MASK_GAIN        16'h01ff
`define OMX_RST_ENABLES      16'h0000
`define OMX_RST_ROUTE        16'h0000
`define OMX_RST_GAIN         16'h013f
`define OMX_RST_AUX_CODE     3'h7

// aux gain code to dB: code * step - floor
`define OMX_AUX_STEP_DB      5'h03
`define OMX_AUX_FLOOR_DB     5'h0f

`endif

// [verilog/omx_pkg.sv]
package omx_pkg;

    // one control register word
    typedef logic [15:0] omx_word_t;

    // six-source routing vector, bit 5 first
    typedef logic [5:0] omx_route_t;

    // three-bit aux gain code
    typedef logic [2:0] omx_aux_code_t;

    // two's complement gain in dB
    typedef logic [4:0] omx_db_t;

endpackage

// [verilog/omx_field_reg.sv]
`timescale 1ns/1ps
`include "omx_cfg.svh"

module omx_field_reg
    import omx_pkg::*;
#(
    parameter omx_word_t MASK = 16'h0000,
    parameter omx_word_t RESET = 16'h0000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // write strobe and data
    input wire logic wr_en_i,
    input wire omx_word_t wr_data_i,
    // stored value, undefined bits zero
    output omx_word_t value_o
);

    omx_word_t value_ff;
    omx_word_t nxt_value;

    // only defined bits take the write
    assign nxt_value = wr_en_i ? (wr_data_i & MASK) : value_ff;

    // storage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            value_ff <= RESET;
        end else begin
            value_ff <= nxt_value;
        end
    end

    assign value_o = value_ff;

    chk_undefined_zero:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (value_o & ~MASK) == 16'h0000)
    else $error("undefined register bit is set");

    chk_write_lands:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_en_i |=> value_o == ($past(wr_data_i) & MASK))
    else $error("written value not held");

    chk_value_holds:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !wr_en_i ##1 rst_n_i |-> $stable(value_o))
    else $error("value changed without a write");

endmodule // omx_field_reg

// [verilog/omx_output_mixer_regs.sv]
// Overview of operation
// - bits 3,2 power headphone mixers, reset off
// - bits 1,0 enable speaker mixers, reset off
// - left headphone stage: converter or mixer
// - right headphone stage: converter or mixer
// - left speaker stage: converter or mixer
// - six source connects into left headphone mixer
// - same six sources into right headphone mixer
// - same six sources into left speaker mixer
// - left headphone mixer mute, resets muted
// - right headphone mixer mute, resets muted
// - input mixers into left headphones: 0/-6dB
// - input mixers into right headphones: 0/-6dB
// - aux left to left phones gain, reset 111
// - aux right to left phones gain, reset 111
// - aux gains into right phones, reset 111
`timescale 1ns/1ps
`include "omx_cfg.svh"

module omx_output_mixer_regs
    import omx_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control port register access
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire omx_word_t reg_wdata_i,
    output omx_word_t reg_rdata_o,
    output logic reg_ack_o,
    output logic reg_miss_o,
    // mixer power controls
    output logic left_phones_mixer_on_o,
    output logic right_phones_mixer_on_o,
    output logic left_loudspeaker_mixer_on_o,
    output logic right_loudspeaker_mixer_on_o,
    // gain stage source selects
    output logic left_phones_path_select_o,
    output logic right_phones_path_select_o,
    output logic left_loudspeaker_path_select_o,
    // source connects, bit 5 left_converter down to bit 0 aux_right_input
    output omx_route_t left_phones_route_o,
    output omx_route_t right_phones_route_o,
    output omx_route_t left_loudspeaker_route_o,
    // headphone mixer mutes
    output logic left_phones_mixer_silence_o,
    output logic right_phones_mixer_silence_o,
    // input mixer gains, 1 means -6dB
    output logic inmix_left_to_left_phones_gain_o,
    output logic inmix_right_to_left_phones_gain_o,
    output logic inmix_left_to_right_phones_gain_o,
    output logic inmix_right_to_right_phones_gain_o,
    // aux gain codes
    output omx_aux_code_t aux_left_to_left_phones_gain_o,
    output omx_aux_code_t aux_right_to_left_phones_gain_o,
    output omx_aux_code_t aux_left_to_right_phones_gain_o,
    output omx_aux_code_t aux_right_to_right_phones_gain_o,
    // aux gains in dB, two's complement
    output omx_db_t aux_left_to_left_phones_db_o,
    output omx_db_t aux_right_to_left_phones_db_o,
    output omx_db_t aux_left_to_right_phones_db_o,
    output omx_db_t aux_right_to_right_phones_db_o
);

    // address decode
    wire logic hit_enables;
    wire logic hit_lhp_route;
    wire logic hit_rhp_route;
    wire logic hit_lhp_gain;
    wire logic hit_rhp_gain;
    wire logic hit_lspk_route;
    wire logic hit_any;

    assign hit_enables = reg_addr_i == `OMX_ADDR_ENABLES;
    assign hit_lhp_route = reg_addr_i == `OMX_ADDR_LHP_ROUTE;
    assign hit_rhp_route = reg_addr_i == `OMX_ADDR_RHP_ROUTE;
    assign hit_lhp_gain = reg_addr_i == `OMX_ADDR_LHP_GAIN;
    assign hit_rhp_gain = reg_addr_i == `OMX_ADDR_RHP_GAIN;
    assign hit_lspk_route = reg_addr_i == `OMX_ADDR_LSPK_ROUTE;
    assign hit_any = hit_enables | hit_lhp_route | hit_rhp_route |
                     hit_lhp_gain | hit_rhp_gain | hit_lspk_route;

    // stored register words
    omx_word_t enables_q;
    omx_word_t lhp_route_q;
    omx_word_t rhp_route_q;
    omx_word_t lhp_gain_q;
    omx_word_t rhp_gain_q;
    omx_word_t lspk_route_q;

    omx_field_reg #(
        .MASK(`OMX_MASK_ENABLES),
        .RESET(`OMX_RST_ENABLES)
    ) u_enables (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(reg_wr_i & hit_enables),
        .wr_data_i(reg_wdata_i),
        .value_o(enables_q)
    );

    omx_field_reg #(
        .MASK(`OMX_MASK_ROUTE),
        .RESET(`OMX_RST_ROUTE)
    ) u_lhp_route (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(reg_wr_i & hit_lhp_route),
        .wr_data_i(reg_wdata_i),
        .value_o(lhp_route_q)
    );

    omx_field_reg #(
        .MASK(`OMX_MASK_ROUTE),
        .RESET(`OMX_RST_ROUTE)
    ) u_rhp_route (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(reg_wr_i & hit_rhp_route),
        .wr_data_i(reg_wdata_i),
        .value_o(rhp_route_q)
    );

    omx_field_reg #(
        .MASK(`OMX_MASK_GAIN),
        .RESET(`OMX_RST_GAIN)
    ) u_lhp_gain (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(reg_wr_i & hit_lhp_gain),
        .wr_data_i(reg_wdata_i),
        .value_o(lhp_gain_q)
    );

    omx_field_reg #(
        .MASK(`OMX_MASK_GAIN),
        .RESET(`OMX_RST_GAIN)
    ) u_rhp_gain (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(reg_wr_i & hit_rhp_gain),
        .wr_data_i(reg_wdata_i),
        .value_o(rhp_gain_q)
    );

    omx_field_reg #(
        .MASK(`OMX_MASK_ROUTE),
        .RESET(`OMX_RST_ROUTE)
    ) u_lspk_route (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(reg_wr_i & hit_lspk_route),
        .wr_data_i(reg_wdata_i),
        .value_o(lspk_route_q)
    );

    // mixer power
    assign left_phones_mixer_on_o = enables_q[`OMX_BIT_LHP_ON];
    assign right_phones_mixer_on_o = enables_q[`OMX_BIT_RHP_ON];
    assign left_loudspeaker_mixer_on_o = enables_q[`OMX_BIT_LSPK_ON];
    assign right_loudspeaker_mixer_on_o = enables_q[`OMX_BIT_RSPK_ON];

    // gain stage feeds: 0 converter direct, 1 mixer output
    assign left_phones_path_select_o = lhp_route_q[`OMX_BIT_PATH_SEL];
    assign right_phones_path_select_o = rhp_route_q[`OMX_BIT_PATH_SEL];
    assign left_loudspeaker_path_select_o =
        lspk_route_q[`OMX_BIT_PATH_SEL];

    // per-source connects
    assign left_phones_route_o =
        lhp_route_q[`OMX_ROUTE_MSB:`OMX_ROUTE_LSB];
    assign right_phones_route_o =
        rhp_route_q[`OMX_ROUTE_MSB:`OMX_ROUTE_LSB];
    assign left_loudspeaker_route_o =
        lspk_route_q[`OMX_ROUTE_MSB:`OMX_ROUTE_LSB];

    // mutes
    assign left_phones_mixer_silence_o = lhp_gain_q[`OMX_BIT_SILENCE];
    assign right_phones_mixer_silence_o = rhp_gain_q[`OMX_BIT_SILENCE];

    // input mixer gain bits
    assign inmix_left_to_left_phones_gain_o =
        lhp_gain_q[`OMX_BIT_INMIX_L_GAIN];
    assign inmix_right_to_left_phones_gain_o =
        lhp_gain_q[`OMX_BIT_INMIX_R_GAIN];
    assign inmix_left_to_right_phones_gain_o =
        rhp_gain_q[`OMX_BIT_INMIX_L_GAIN];
    assign inmix_right_to_right_phones_gain_o =
        rhp_gain_q[`OMX_BIT_INMIX_R_GAIN];

    // aux gain codes
    assign aux_left_to_left_phones_gain_o =
        lhp_gain_q[`OMX_AUXL_MSB:`OMX_AUXL_LSB];
    assign aux_right_to_left_phones_gain_o =
        lhp_gain_q[`OMX_AUXR_MSB:`OMX_AUXR_LSB];
    assign aux_left_to_right_phones_gain_o =
        rhp_gain_q[`OMX_AUXL_MSB:`OMX_AUXL_LSB];
    assign aux_right_to_right_phones_gain_o =
        rhp_gain_q[`OMX_AUXR_MSB:`OMX_AUXR_LSB];

    // code to dB, wraps into two's complement on 5 bits
    function automatic omx_db_t aux_db(input omx_aux_code_t code);
        omx_db_t scaled;
        scaled = 5'({2'b00, code} * `OMX_AUX_STEP_DB);
        return scaled - `OMX_AUX_FLOOR_DB;
    endfunction

    // dB view of the aux gains, one cycle behind the codes
    omx_db_t aux_ll_db_ff;
    omx_db_t aux_rl_db_ff;
    omx_db_t aux_lr_db_ff;
    omx_db_t aux_rr_db_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            aux_ll_db_ff <= aux_db(`OMX_RST_AUX_CODE);
            aux_rl_db_ff <= aux_db(`OMX_RST_AUX_CODE);
            aux_lr_db_ff <= aux_db(`OMX_RST_AUX_CODE);
            aux_rr_db_ff <= aux_db(`OMX_RST_AUX_CODE);
        end else begin
            aux_ll_db_ff <= aux_db(aux_left_to_left_phones_gain_o);
            aux_rl_db_ff <= aux_db(aux_right_to_left_phones_gain_o);
            aux_lr_db_ff <= aux_db(aux_left_to_right_phones_gain_o);
            aux_rr_db_ff <= aux_db(aux_right_to_right_phones_gain_o);
        end
    end

    assign aux_left_to_left_phones_db_o = aux_ll_db_ff;
    assign aux_right_to_left_phones_db_o = aux_rl_db_ff;
    assign aux_left_to_right_phones_db_o = aux_lr_db_ff;
    assign aux_right_to_right_phones_db_o = aux_rr_db_ff;

    // read selection, unmapped reads give zero
    wire omx_word_t rd_sel;

    assign rd_sel = hit_enables ? enables_q :
                    hit_lhp_route ? lhp_route_q :
                    hit_rhp_route ? rhp_route_q :
                    hit_lhp_gain ? lhp_gain_q :
                    hit_rhp_gain ? rhp_gain_q :
                    hit_lspk_route ? lspk_route_q :
                    16'h0000;

    // answer one cycle after each access
    omx_word_t rdata_ff;
    logic ack_ff;
    logic miss_ff;
    logic access;

    assign access = reg_wr_i | reg_rd_i;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_ff <= 16'h0000;
            ack_ff <= 1'b0;
            miss_ff <= 1'b0;
        end else begin
            rdata_ff <= reg_rd_i ? rd_sel : rdata_ff;
            ack_ff <= access;
            miss_ff <= access & ~hit_any;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign reg_ack_o = ack_ff;
    assign reg_miss_o = miss_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_enables_reset:
    assert property ($rose(rst_n_i) |-> !left_phones_mixer_on_o &&
        !right_phones_mixer_on_o)
    else $error("headphone mixer on after reset");

    chk_speaker_enable:
    assert property (reg_wr_i && hit_enables |=>
        left_loudspeaker_mixer_on_o == $past(reg_wdata_i[1]) &&
        right_loudspeaker_mixer_on_o == $past(reg_wdata_i[0]))
    else $error("speaker mixer enable not taken");

    chk_phones_path:
    assert property (reg_wr_i && hit_lhp_route |=>
        left_phones_path_select_o == $past(reg_wdata_i[7]))
    else $error("left headphone path select wrong");

    chk_right_path:
    assert property (reg_wr_i && hit_rhp_route |=>
        right_phones_path_select_o == $past(reg_wdata_i[7]))
    else $error("right headphone path select wrong");

    chk_speaker_route:
    assert property (reg_wr_i && hit_lspk_route |=>
        {left_loudspeaker_path_select_o, left_loudspeaker_route_o} ==
        {$past(reg_wdata_i[7]), $past(reg_wdata_i[5:0])})
    else $error("speaker route not taken");

    chk_route_hold:
    assert property (!(reg_wr_i && hit_lhp_route) |=>
        $stable(left_phones_route_o))
    else $error("left headphone route moved");

    chk_mute_reset:
    assert property ($rose(rst_n_i) |-> left_phones_mixer_silence_o &&
        right_phones_mixer_silence_o)
    else $error("headphone mixer not muted after reset");

    chk_aux_reset:
    assert property ($rose(rst_n_i) |->
        aux_left_to_left_phones_gain_o == 3'h7 &&
        aux_right_to_right_phones_gain_o == 3'h7)
    else $error("aux gain not at +6dB after reset");

    chk_gain_write:
    assert property (reg_wr_i && hit_rhp_gain |=>
        inmix_left_to_right_phones_gain_o == $past(reg_wdata_i[7]) &&
        right_phones_mixer_silence_o == $past(reg_wdata_i[8]))
    else $error("right headphone gain word not taken");

    chk_db_decode:
    assert property (##1 aux_right_to_left_phones_db_o ==
        5'($past(aux_right_to_left_phones_gain_o) * 3) - 5'h0f)
    else $error("aux dB value does not match code");

    chk_read_back:
    assert property (reg_rd_i && !hit_any |=> reg_rdata_o == 16'h0000 &&
        reg_miss_o && reg_ack_o)
    else $error("unmapped read not answered with zero");

endmodule // omx_output_mixer_regs

// [tb/testbench.sv]
`timescale 1ns/1ps
`include "omx_cfg.svh"

module testbench
    import omx_pkg::*;
;
    // stimulus and design outputs
    logic clk, rst_n, wr, rd, ack, miss;
    logic [7:0] addr;
    omx_word_t wdata, rdata;
    logic lp_on, rp_on, ls_on, rs_on, lp_sel, rp_sel, ls_sel;
    logic lp_sil, rp_sil, g_ll, g_rl, g_lr, g_rr;
    omx_route_t lp_rt, rp_rt, ls_rt;
    omx_aux_code_t a_ll, a_rl, a_lr, a_rr;
    omx_db_t d_ll, d_rl, d_lr, d_rr;
    int errors, n_compared, cycles;
    logic [7:0] addr_tab [6] = '{`OMX_ADDR_ENABLES, `OMX_ADDR_LHP_ROUTE,
        `OMX_ADDR_RHP_ROUTE, `OMX_ADDR_LHP_GAIN, `OMX_ADDR_RHP_GAIN,
        `OMX_ADDR_LSPK_ROUTE};
    omx_word_t mask_tab [6] = '{`OMX_MASK_ENABLES, `OMX_MASK_ROUTE,
        `OMX_MASK_ROUTE, `OMX_MASK_GAIN, `OMX_MASK_GAIN, `OMX_MASK_ROUTE};
    omx_word_t rst_tab [6] = '{`OMX_RST_ENABLES, `OMX_RST_ROUTE,
        `OMX_RST_ROUTE, `OMX_RST_GAIN, `OMX_RST_GAIN, `OMX_RST_ROUTE};
    logic [7:0] miss_tab [4] = '{8'h00, 8'h62, 8'h68, 8'h6a};

    omx_output_mixer_regs dut_u (
        .clk_i(clk), .rst_n_i(rst_n),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_ack_o(ack), .reg_miss_o(miss),
        .left_phones_mixer_on_o(lp_on), .right_phones_mixer_on_o(rp_on),
        .left_loudspeaker_mixer_on_o(ls_on),
        .right_loudspeaker_mixer_on_o(rs_on),
        .left_phones_path_select_o(lp_sel),
        .right_phones_path_select_o(rp_sel),
        .left_loudspeaker_path_select_o(ls_sel),
        .left_phones_route_o(lp_rt), .right_phones_route_o(rp_rt),
        .left_loudspeaker_route_o(ls_rt),
        .left_phones_mixer_silence_o(lp_sil),
        .right_phones_mixer_silence_o(rp_sil),
        .inmix_left_to_left_phones_gain_o(g_ll),
        .inmix_right_to_left_phones_gain_o(g_rl),
        .inmix_left_to_right_phones_gain_o(g_lr),
        .inmix_right_to_right_phones_gain_o(g_rr),
        .aux_left_to_left_phones_gain_o(a_ll),
        .aux_right_to_left_phones_gain_o(a_rl),
        .aux_left_to_right_phones_gain_o(a_lr),
        .aux_right_to_right_phones_gain_o(a_rr),
        .aux_left_to_left_phones_db_o(d_ll),
        .aux_right_to_left_phones_db_o(d_rl),
        .aux_left_to_right_phones_db_o(d_lr),
        .aux_right_to_right_phones_db_o(d_rr)
    );

    // clock generator, 5 ns period
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            report_and_stop();
        end
    end

    // control outputs gathered back into register layout
    function automatic omx_word_t view(input logic [7:0] a);
        case (a)
            `OMX_ADDR_ENABLES: view = {12'h000, lp_on, rp_on, ls_on, rs_on};
            `OMX_ADDR_LHP_ROUTE: view = {8'h00, lp_sel, 1'h0, lp_rt};
            `OMX_ADDR_RHP_ROUTE: view = {8'h00, rp_sel, 1'h0, rp_rt};
            `OMX_ADDR_LSPK_ROUTE: view = {8'h00, ls_sel, 1'h0, ls_rt};
            `OMX_ADDR_LHP_GAIN: view = {7'h00, lp_sil, g_ll, g_rl, a_ll, a_rl};
            `OMX_ADDR_RHP_GAIN: view = {7'h00, rp_sil, g_lr, g_rr, a_lr, a_rr};
            default: view = 16'h0000;
        endcase
    endfunction

    // compare and count
    task automatic chk(input string what, input omx_word_t seen,
                       input omx_word_t exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one access; strobes stay up so calls may run back to back
    task automatic access(input logic w, input logic r, input logic [7:0] a,
                          input omx_word_t d, input logic m,
                          input omx_word_t e);
        wr = w;
        rd = r;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        chk("ack", {15'h0000, ack}, 16'h0001);
        chk("miss", {15'h0000, miss}, {15'h0000, m});
        if (r) begin
            chk("rdata", rdata, e);
        end
    endtask

    // drop strobes for one cycle, ack must fall
    task automatic idle();
        wr = 1'h0;
        rd = 1'h0;
        @(posedge clk);
        #1;
        chk("ack idle", {15'h0000, ack}, 16'h0000);
    endtask

    // reset values on outputs, db view of code 7 is +6
    task automatic check_reset();
        for (int i = 0; i < 6; i++) begin
            chk("reset view", view(addr_tab[i]), rst_tab[i]);
        end
        chk("db ll", {11'h000, d_ll}, 16'h0006);
        chk("db rl", {11'h000, d_rl}, 16'h0006);
        chk("db rr", {11'h000, d_rr}, 16'h0006);
        chk("db lr", {11'h000, d_lr}, 16'h0006);
    endtask

    task automatic report_and_stop();
        if (errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        logic [4:0] e;
        omx_word_t x;
        errors = 0;
        n_compared = 0;
        cycles = 0;
        rst_n = 1'h0;
        wr = 1'h0;
        rd = 1'h0;
        addr = 8'h00;
        wdata = 16'h0000;
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'h1;
        check_reset();
        for (int i = 0; i < 6; i++) begin
            access(1'h0, 1'h1, addr_tab[i], 16'h0000, 1'h0, rst_tab[i]);
        end
        // walking one through every bit of every register
        for (int i = 0; i < 6; i++) begin
            for (int b = 0; b < 16; b++) begin
                x = 16'h0001 << b;
                access(1'h1, 1'h0, addr_tab[i], x, 1'h0, 16'h0000);
                chk("walk", view(addr_tab[i]), x & mask_tab[i]);
                access(1'h0, 1'h1, addr_tab[i], 16'h0000, 1'h0,
                       x & mask_tab[i]);
            end
            access(1'h1, 1'h0, addr_tab[i], 16'hffff, 1'h0, 16'h0000);
            chk("ones", view(addr_tab[i]), mask_tab[i]);
        end
        // unmapped places answer with miss and leave registers alone
        for (int j = 0; j < 4; j++) begin
            access(1'h1, 1'h0, miss_tab[j], 16'h0000, 1'h1, 16'h0000);
            access(1'h0, 1'h1, miss_tab[j], 16'h0000, 1'h1, 16'h0000);
        end
        for (int i = 0; i < 6; i++) begin
            chk("kept", view(addr_tab[i]), mask_tab[i]);
        end
        // read and write together return the old word
        access(1'h1, 1'h1, `OMX_ADDR_LHP_ROUTE, 16'h00ea, 1'h0, 16'h00bf);
        access(1'h0, 1'h1, `OMX_ADDR_LHP_ROUTE, 16'h0000, 1'h0, 16'h00aa);
        // every aux gain code and its dB value
        for (int c = 0; c < 8; c++) begin
            access(1'h1, 1'h0, `OMX_ADDR_LHP_GAIN, {10'h000, 3'(c), ~3'(c)},
                   1'h0, 16'h0000);
            access(1'h1, 1'h0, `OMX_ADDR_RHP_GAIN, {10'h2c3, ~3'(c), 3'(c)},
                   1'h0, 16'h0000);
            idle();
            e = 5'(c * 3) - `OMX_AUX_FLOOR_DB;
            chk("db ll", {11'h000, d_ll}, {11'h000, e});
            chk("db rr", {11'h000, d_rr}, {11'h000, e});
            e = 5'((7 - c) * 3) - `OMX_AUX_FLOOR_DB;
            chk("db rl", {11'h000, d_rl}, {11'h000, e});
            chk("db lr", {11'h000, d_lr}, {11'h000, e});
            chk("inmix r", view(`OMX_ADDR_RHP_GAIN) & 16'h01c0,
                16'h00c0);
        end
        // second reset in mid-run with a write held against it
        for (int i = 0; i < 6; i++) begin
            access(1'h1, 1'h0, addr_tab[i], 16'hffff, 1'h0, 16'h0000);
        end
        idle();
        rst_n = 1'h0;
        wr = 1'h1;
        addr = `OMX_ADDR_ENABLES;
        wdata = 16'hffff;
        repeat (2) @(posedge clk);
        #1;
        chk("ack in reset", {15'h0000, ack}, 16'h0000);
        rst_n = 1'h1;
        wr = 1'h0;
        check_reset();
        access(1'h0, 1'h1, `OMX_ADDR_LHP_GAIN, 16'h0000, 1'h0,
               `OMX_RST_GAIN);
        idle();
        report_and_stop();
    end
endmodule // testbench
